// ---- rtl/ccr_bank.v ----
// codec control register bank with program-mode word handling and cascade forward
`timescale 1ns/1ps
`include "ccr_defs.vh"

// ---------------------------------------------
// word fifo
// ---------------------------------------------
module ccr_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire             ref_clk_in,
	input  wire             rst_in,
	input  wire [WIDTH-1:0] wr_data_in,
	input  wire             wr_valid_in,
	output wire             wr_ready_out,
	output wire [WIDTH-1:0] rd_data_out,
	output wire             rd_valid_out,
	input  wire             rd_ready_in
);
	reg  [WIDTH-1:0] mem [0:DEPTH-1];
	reg  [AW:0]      wr_ptr_r;
	reg  [AW:0]      rd_ptr_r;
	wire             full_w;
	wire             empty_w;
	assign full_w       = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
	assign empty_w      = (wr_ptr_r == rd_ptr_r);
	assign wr_ready_out = ~full_w;
	assign rd_valid_out = ~empty_w;
	assign rd_data_out  = mem[rd_ptr_r[AW-1:0]];
	always @(posedge ref_clk_in)
	begin
		if (wr_valid_in && !full_w)
			mem[wr_ptr_r[AW-1:0]] <= wr_data_in;
	end
	always @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			wr_ptr_r <= {(AW+1){1'b0}};
			rd_ptr_r <= {(AW+1){1'b0}};
		end
		else
		begin
			if (wr_valid_in && !full_w)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (rd_ready_in && !empty_w)
				rd_ptr_r <= rd_ptr_r + 1'b1;
		end
	end
endmodule

// Operation
// - register a bit 0: 0 program mode, 1 data mode
// - register a bit 1 enables mixed program/data mode
// - register a bits 2 and 3 enable digital and port loop-back
// - register a bits 4-6 hold device count, bit 4 lsb
// - writing 1 to register a bit 7 starts software reset
// - register b: rate bits 0-1, serial divider 2-3, master divider 4-6
// - register b bit 7 enables control echo
// - register c: global power 0, adc 3, dac 4, reference 5, refout 6
// - register d: input gain 0-2, modulator reset 3, output gain 4-6, mute 7
// - register e: dac advance 0-4, interpolator bypass bit 5
// - register f: single-ended 5, input invert 6, analog loop-back 7
// - register changes accepted only in program or mixed mode
// - every transfer is a 16-bit packet
// - in program mode each packet is a control word
// - device address zero means the word is for this device
// - nonzero address is decremented and the word forwarded out
// - after reset with port enable, frame sync marks each output sample
// - frame sync at master clock/2048 until register b written, then rate bits
// - word: 15 control flag, 14 read/write, 13-11 device, 10-8 register, 7-0 data
// - hardware or software reset zeroes all registers over 4 clock cycles
module ccr_bank (
	input  wire        ref_clk_in,
	input  wire        sys_rst_in,
	input  wire [15:0] word_in,
	input  wire        word_valid_in,
	output reg         word_ready_out,
	input  wire        port_enable_pin_in,
	output reg  [15:0] fwd_word_out,
	output reg         fwd_valid_out,
	input  wire        fwd_ready_in,
	output reg         output_frame_sync_out,
	output reg  [7:0]  control_reg_a_out,
	output reg  [7:0]  control_reg_b_out,
	output reg  [7:0]  control_reg_c_out,
	output reg  [7:0]  control_reg_d_out,
	output reg  [7:0]  control_reg_e_out,
	output reg  [7:0]  control_reg_f_out,
	output reg         in_reset_out
);
	// ---------------------------------------------
	// internal state
	// ---------------------------------------------
	reg  [7:0]  reg_a_r;
	reg  [7:0]  reg_b_r;
	reg  [7:0]  reg_c_r;
	reg  [7:0]  reg_d_r;
	reg  [7:0]  reg_e_r;
	reg  [7:0]  reg_f_r;
	reg  [2:0]  rst_cnt_r;
	reg         b_written_r;
	reg  [11:0] fs_cnt_r;
	reg         pe_meta_r;
	reg         pe_sync_r;
	reg  [15:0] q_data_r;
	reg         q_valid_r;
	wire        soft_busy_w;
	wire [15:0] ff_data_w;
	wire        ff_valid_w;
	wire        ff_ready_w;
	wire        cfg_ok_w;
	wire        take_w;
	wire [2:0]  dev_w;
	wire [2:0]  sel_w;
	wire        for_me_w;
	wire        is_ctrl_w;
	wire [11:0] fs_div_w;
	wire        fs_hit_w;
	wire        out_load_w;

	assign soft_busy_w = (rst_cnt_r != 3'h0);
	// ---------------------------------------------
	// incoming words pass through the fifo; it is not read while reset runs and stalls the source only when full
	// ---------------------------------------------
	ccr_fifo #(
		.WIDTH (`CCR_WORD_BITS),
		.DEPTH (`CCR_FIFO_DEPTH),
		.AW    (`CCR_FIFO_AW)
	) u_fifo (
		.ref_clk_in   (ref_clk_in),
		.rst_in       (sys_rst_in),
		.wr_data_in   (word_in),
		.wr_valid_in  (word_valid_in),
		.wr_ready_out (ff_ready_w),
		.rd_data_out  (ff_data_w),
		.rd_valid_out (ff_valid_w),
		.rd_ready_in  (take_w)
	);

	// forwarded words wait in a one-word holding slot, so a stalled
	// downstream port backs up into the fifo instead of dropping words
	// the slot moves into the output register only when that register is free or drained
	assign out_load_w = q_valid_r && (!fwd_valid_out || fwd_ready_in);
	assign take_w    = ff_valid_w && !soft_busy_w && !(q_valid_r && !out_load_w);
	assign dev_w     = ff_data_w[`CCR_CW_DEV_HI:`CCR_CW_DEV_LO];
	assign sel_w     = ff_data_w[`CCR_CW_REG_HI:`CCR_CW_REG_LO];
	assign is_ctrl_w = ff_data_w[`CCR_CW_CTRL];
	assign for_me_w  = (dev_w == 3'h0);
	// data mode without mixed mode locks the registers until hardware reset
	assign cfg_ok_w  = !reg_a_r[`CCR_A_MODE] || reg_a_r[`CCR_A_MIXED];

	// ---------------------------------------------
	// registers
	// ---------------------------------------------
	always @(posedge ref_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			reg_a_r     <= `CCR_REG_RESET;
			reg_b_r     <= `CCR_REG_RESET;
			reg_c_r     <= `CCR_REG_RESET;
			reg_d_r     <= `CCR_REG_RESET;
			reg_e_r     <= `CCR_REG_RESET;
			reg_f_r     <= `CCR_REG_RESET;
			rst_cnt_r   <= `CCR_RESET_CYCLES;
			b_written_r <= 1'b0;
			q_data_r    <= 16'h0000;
			q_valid_r   <= 1'b0;
		end
		else
		begin
			if (out_load_w)
				q_valid_r <= 1'b0;
			if (soft_busy_w)
			begin
				// reset holds the bank at zero for the full count
				rst_cnt_r   <= rst_cnt_r - 3'h1;
				reg_a_r     <= `CCR_REG_RESET;
				reg_b_r     <= `CCR_REG_RESET;
				reg_c_r     <= `CCR_REG_RESET;
				reg_d_r     <= `CCR_REG_RESET;
				reg_e_r     <= `CCR_REG_RESET;
				reg_f_r     <= `CCR_REG_RESET;
				b_written_r <= 1'b0;
			end
			else if (take_w)
			begin
				// each 16-bit entry is one packet; a clear flag bit in
				// program mode is an invalid word and is dropped
				if (!for_me_w && is_ctrl_w && cfg_ok_w)
				begin
					q_data_r  <= {ff_data_w[15:14], dev_w - 3'h1, ff_data_w[10:0]};
					q_valid_r <= 1'b1;
				end
				else if (for_me_w && is_ctrl_w && cfg_ok_w && !ff_data_w[`CCR_CW_RW])
				begin
					if (sel_w == `CCR_ADDR_A)
					begin
						// bit 7 is a strobe: it starts reset and is never stored
						reg_a_r <= {1'b0, ff_data_w[6:0]};
						if (ff_data_w[`CCR_A_SWRST])
							rst_cnt_r <= `CCR_RESET_CYCLES;
					end
					else if (sel_w == `CCR_ADDR_B)
					begin
						reg_b_r     <= ff_data_w[7:0];
						b_written_r <= 1'b1;
					end
					else if (sel_w == `CCR_ADDR_C)
						reg_c_r <= ff_data_w[7:0];
					else if (sel_w == `CCR_ADDR_D)
						reg_d_r <= ff_data_w[7:0];
					else if (sel_w == `CCR_ADDR_E)
						reg_e_r <= ff_data_w[7:0];
					else if (sel_w == `CCR_ADDR_F)
						reg_f_r <= ff_data_w[7:0];
					// codes 6 and 7 fall through untouched
				end
				else if (for_me_w && is_ctrl_w && cfg_ok_w)
				begin
					// read: selected register goes into the data field and out
					q_valid_r <= 1'b1;
					if (sel_w == `CCR_ADDR_A)
						q_data_r <= {ff_data_w[15:8], reg_a_r};
					else if (sel_w == `CCR_ADDR_B)
						q_data_r <= {ff_data_w[15:8], reg_b_r};
					else if (sel_w == `CCR_ADDR_C)
						q_data_r <= {ff_data_w[15:8], reg_c_r};
					else if (sel_w == `CCR_ADDR_D)
						q_data_r <= {ff_data_w[15:8], reg_d_r};
					else if (sel_w == `CCR_ADDR_E)
						q_data_r <= {ff_data_w[15:8], reg_e_r};
					else if (sel_w == `CCR_ADDR_F)
						q_data_r <= {ff_data_w[15:8], reg_f_r};
					else
						q_data_r <= {ff_data_w[15:8], 8'h00};
				end
			end
		end
	end

	// ---------------------------------------------
	// output frame sync timing
	// ---------------------------------------------
	// default rate until register b is written, then 2048 >> rate select
	assign fs_div_w = b_written_r ? (`CCR_FS_DIV_BASE >> reg_b_r[1:0]) : `CCR_FS_DIV_BASE;
	assign fs_hit_w = (fs_cnt_r == fs_div_w - 12'h001);

	always @(posedge ref_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			pe_meta_r             <= 1'b0;
			pe_sync_r             <= 1'b0;
			fs_cnt_r              <= 12'h000;
			output_frame_sync_out <= 1'b0;
		end
		else
		begin
			pe_meta_r <= port_enable_pin_in;
			pe_sync_r <= pe_meta_r;
			// counter also restarts when a rate change leaves it at or past the new period
			if (!pe_sync_r || soft_busy_w || fs_hit_w || fs_cnt_r >= fs_div_w)
				fs_cnt_r <= 12'h000;
			else
				fs_cnt_r <= fs_cnt_r + 12'h001;
			output_frame_sync_out <= pe_sync_r && !soft_busy_w && fs_hit_w;
		end
	end

	// ---------------------------------------------
	// registered outputs
	// ---------------------------------------------
	always @(posedge ref_clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			control_reg_a_out <= 8'h00;
			control_reg_b_out <= 8'h00;
			control_reg_c_out <= 8'h00;
			control_reg_d_out <= 8'h00;
			control_reg_e_out <= 8'h00;
			control_reg_f_out <= 8'h00;
			fwd_word_out      <= 16'h0000;
			fwd_valid_out     <= 1'b0;
			word_ready_out    <= 1'b0;
			in_reset_out      <= 1'b1;
		end
		else
		begin
			control_reg_a_out <= reg_a_r;
			control_reg_b_out <= reg_b_r;
			control_reg_c_out <= reg_c_r;
			control_reg_d_out <= reg_d_r;
			control_reg_e_out <= reg_e_r;
			control_reg_f_out <= reg_f_r;
			// word and valid hold until the downstream side takes them
			if (out_load_w)
			begin
				fwd_word_out  <= q_data_r;
				fwd_valid_out <= 1'b1;
			end
			else if (fwd_ready_in)
				fwd_valid_out <= 1'b0;
			word_ready_out    <= ff_ready_w;
			in_reset_out      <= soft_busy_w;
		end
	end
endmodule

// ---- rtl/ccr_defs.vh ----
// constants for the codec control register bank
`ifndef CCR_DEFS_VH
`define CCR_DEFS_VH
// ---------------------------------------------
// register address codes and reset value
// ---------------------------------------------
`define CCR_ADDR_A        3'h0
`define CCR_ADDR_B        3'h1
`define CCR_ADDR_C        3'h2
`define CCR_ADDR_D        3'h3
`define CCR_ADDR_E        3'h4
`define CCR_ADDR_F        3'h5
`define CCR_REG_RESET     8'h00
// ---------------------------------------------
// control word fields
// ---------------------------------------------
`define CCR_CW_CTRL       15
`define CCR_CW_RW         14
`define CCR_CW_DEV_HI     13
`define CCR_CW_DEV_LO     11
`define CCR_CW_REG_HI     10
`define CCR_CW_REG_LO     8
// ---------------------------------------------
// register a bits
// ---------------------------------------------
`define CCR_A_MODE        0
`define CCR_A_MIXED       1
`define CCR_A_DLB         2
`define CCR_A_PLB         3
`define CCR_A_SWRST       7
// ---------------------------------------------
// timing and sizes
// ---------------------------------------------
`define CCR_RESET_CYCLES  3'h4
`define CCR_FS_DIV_BASE   12'h800
`define CCR_WORD_BITS     16
`define CCR_FIFO_DEPTH    8
`define CCR_FIFO_AW       3
`endif

// ---- tb/ccr_bank_props.sv ----
// assertion checker for the codec control register bank
`timescale 1ns/1ps
module ccr_bank_props (
	input wire        ref_clk_in,
	input wire        sys_rst_in,
	input wire [15:0] word_in,
	input wire        word_valid_in,
	input wire        word_ready_out,
	input wire        port_enable_pin_in,
	input wire [15:0] fwd_word_out,
	input wire        fwd_valid_out,
	input wire        fwd_ready_in,
	input wire        output_frame_sync_out,
	input wire [7:0]  control_reg_a_out,
	input wire [7:0]  control_reg_b_out,
	input wire [7:0]  control_reg_c_out,
	input wire [7:0]  control_reg_d_out,
	input wire [7:0]  control_reg_e_out,
	input wire [7:0]  control_reg_f_out,
	input wire        in_reset_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);
	// interval gap since last sync; an interval touched by a rate change is skipped
	reg [11:0] gap_r;
	reg        chg_r;
	reg [7:0]  b_r;
	always @(posedge ref_clk_in or posedge sys_rst_in)
		if (sys_rst_in)
		begin
			gap_r <= 12'h000;
			chg_r <= 1'b1;
			b_r   <= 8'h00;
		end
		else
		begin
			b_r   <= control_reg_b_out;
			gap_r <= output_frame_sync_out ? 12'h000 : gap_r + 12'h001;
			chg_r <= (chg_r && !output_frame_sync_out) || in_reset_out
				|| b_r != control_reg_b_out || !port_enable_pin_in;
		end
	sequence s_hw_release;
		$fell(sys_rst_in);
	endsequence
	sequence s_reset_done;
		$fell(in_reset_out);
	endsequence
	property p_rst_busy;
		s_hw_release |-> in_reset_out;
	endproperty
	a_rst_busy: assert property (p_rst_busy) else $error("busy low at reset release");
	property p_rst_bound;
		in_reset_out |-> ##[1:5] !in_reset_out;
	endproperty
	a_rst_bound: assert property (p_rst_bound) else $error("reset runs too long");
	property p_rst_zero;
		s_reset_done |-> {control_reg_a_out, control_reg_b_out, control_reg_c_out,
			control_reg_d_out, control_reg_e_out, control_reg_f_out} == 48'h0;
	endproperty
	a_rst_zero: assert property (p_rst_zero) else $error("registers not zero after reset");
	property p_swrst_bit;
		control_reg_a_out[7] == 1'b0;
	endproperty
	a_swrst_bit: assert property (p_swrst_bit) else $error("reset bit stored");
	property p_mode_freeze;
		control_reg_a_out[0] && !control_reg_a_out[1] |=> $stable({control_reg_a_out,
			control_reg_b_out, control_reg_c_out, control_reg_d_out, control_reg_e_out,
			control_reg_f_out});
	endproperty
	a_mode_freeze: assert property (p_mode_freeze) else $error("write taken in data mode");
	property p_fs_pulse;
		output_frame_sync_out |=> !output_frame_sync_out;
	endproperty
	a_fs_pulse: assert property (p_fs_pulse) else $error("frame sync longer than one cycle");
	property p_fs_rate;
		output_frame_sync_out && !chg_r && b_r == control_reg_b_out
			|-> gap_r == (12'h800 >> control_reg_b_out[1:0]) - 12'h001;
	endproperty
	a_fs_rate: assert property (p_fs_rate) else $error("frame sync period wrong");
	property p_fwd_flag;
		fwd_valid_out |-> fwd_word_out[15];
	endproperty
	a_fwd_flag: assert property (p_fwd_flag) else $error("forwarded word lacks control flag");
	property p_fwd_hold;
		fwd_valid_out && !fwd_ready_in |=> fwd_valid_out && $stable(fwd_word_out);
	endproperty
	a_fwd_hold: assert property (p_fwd_hold) else $error("forwarded word dropped while stalled");
endmodule
bind ccr_bank ccr_bank_props ccr_bank_props_inst (.*);

// ---- tb/ccr_bank_tb_top.sv ----
// self-checking bench for the codec control register bank
`timescale 1ns/1ps
module ccr_bank_tb_top;
	reg         ref_clk_in;
	reg         sys_rst_in;
	reg  [15:0] word_in;
	reg         word_valid_in;
	reg         port_enable_pin_in;
	reg         stall;
	wire        word_ready_out;
	wire        fwd_ready_in;
	wire        fwd_valid_out;
	wire        output_frame_sync_out;
	wire        in_reset_out;
	wire [15:0] fwd_word_out;
	wire [7:0]  ra, rb, rc, rd, re, rf;
	integer     n_fail;
	integer     checked;
	integer     i;
	integer     k;
	initial
	begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end
	ccr_bank ccr_bank_inst (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .word_in(word_in),
		.word_valid_in(word_valid_in), .word_ready_out(word_ready_out),
		.port_enable_pin_in(port_enable_pin_in), .fwd_word_out(fwd_word_out),
		.fwd_valid_out(fwd_valid_out), .fwd_ready_in(fwd_ready_in),
		.output_frame_sync_out(output_frame_sync_out), .control_reg_a_out(ra),
		.control_reg_b_out(rb), .control_reg_c_out(rc), .control_reg_d_out(rd),
		.control_reg_e_out(re), .control_reg_f_out(rf), .in_reset_out(in_reset_out));
	ccr_host_model ccr_host_model_inst (.ref_clk_in(ref_clk_in), .fwd_word_in(fwd_word_out),
		.fwd_valid_in(fwd_valid_out), .stall_in(stall), .fwd_ready_out(fwd_ready_in));
	task check(input [47:0] single_ended_input, input [47:0] exp, input string what);
		begin
			checked = checked + 1;
			if (single_ended_input !== exp)
			begin
				n_fail = n_fail + 1;
				$display("ERROR %s expected %h single_ended_input %h", what, exp, single_ended_input);
			end
		end
	endtask
	task wrap_up;
		begin
			$display("checked %0d failed %0d", checked, n_fail);
			if (n_fail == 0 && checked > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	task hang;
		begin
			n_fail = n_fail + 1;
			wrap_up;
		end
	endtask
	task cyc(input integer n);
		repeat (n) @(negedge ref_clk_in);
	endtask
	task hw_reset;
		begin
			sys_rst_in = 1'b1;
			cyc(20);
			sys_rst_in = 1'b0;
			cyc(10);
		end
	endtask
	// three-cycle spacing lets the late ready flag catch up with each push
	task push(input [15:0] w);
		integer n;
		begin
			n = 0;
			while (word_ready_out !== 1'b1 && n < 50)
			begin
				n = n + 1;
				cyc(1);
			end
			if (n == 50)
				hang;
			word_in = w;
			word_valid_in = 1'b1;
			cyc(1);
			word_valid_in = 1'b0;
			cyc(2);
		end
	endtask
	task wr(input [2:0] r, input [7:0] d);
		push({5'h10, r, d});
	endtask
	task wait_fs(output integer n);
		begin
			n = 0;
			do
			begin
				cyc(1);
				n = n + 1;
			end
			while (output_frame_sync_out !== 1'b1 && n < 4200);
			if (n >= 4200)
				hang;
		end
	endtask
	task measure(input integer p);
		integer n;
		begin
			wait_fs(n);
			wait_fs(n);
			wait_fs(n);
			check(48'(n), 48'(p), "sync period");
		end
	endtask
	task t_regs;
		begin
			check({ra, rb, rc, rd, re, rf}, 48'h0, "reset values");
			wr(3'h1, 8'hF5);
			wr(3'h2, 8'h79);
			wr(3'h3, 8'hB6);
			wr(3'h4, 8'h3F);
			wr(3'h5, 8'hE0);
			wr(3'h6, 8'hFF);
			wr(3'h7, 8'hFF);
			push(16'h02FF);
			wr(3'h0, 8'h7C);
			cyc(8);
			check({ra, rb, rc, rd, re, rf}, 48'h7CF579B63FE0, "all regs");
			push(16'hC100);
			cyc(8);
			check(48'(ccr_host_model_inst.got.size()), 48'h1, "read count");
			if (ccr_host_model_inst.got.size() > 0)
				check(48'(ccr_host_model_inst.got[0]), 48'hC1F5, "read back");
			ccr_host_model_inst.got.delete();
			$display("test regs done");
		end
	endtask
	task t_swrst;
		begin
			wr(3'h0, 8'h80);
			k = 0;
			while (in_reset_out !== 1'b1 && k < 10)
			begin
				k = k + 1;
				cyc(1);
			end
			check(48'(in_reset_out), 48'h1, "soft reset busy");
			cyc(12);
			check({ra, rb, rc, rd, re, rf}, 48'h0, "soft reset regs");
			$display("test soft reset done");
		end
	endtask
	task t_fill;
		begin
			stall = 1'b1;
			for (k = 0; k < 16 && word_ready_out === 1'b1; k = k + 1)
			begin
				word_in = {5'h11, 3'h3, 8'(k)};
				word_valid_in = 1'b1;
				cyc(1);
				word_valid_in = 1'b0;
				cyc(2);
			end
			check(48'(k >= 8 && k < 16), 48'h1, "fifo refuses");
			stall = 1'b0;
			cyc(60);
			check(48'(ccr_host_model_inst.got.size()), 48'(k), "forward count");
			for (i = 0; i < k && i < ccr_host_model_inst.got.size(); i = i + 1)
				check(48'(ccr_host_model_inst.got[i]), {32'h0, 5'h10, 3'h3, 8'(i)}, "fwd word");
			check(48'(rd), 48'h0, "not for this device");
			$display("test forward done");
		end
	endtask
	task t_modes;
		begin
			wr(3'h0, 8'h03);
			wr(3'h4, 8'h15);
			cyc(6);
			check({ra, re}, 16'h0315, "mixed mode write");
			wr(3'h0, 8'h01);
			wr(3'h4, 8'h0A);
			wr(3'h0, 8'h80);
			cyc(12);
			check({ra, re}, 16'h0115, "data mode frozen");
			hw_reset;
			check({ra, rb, rc, rd, re, rf}, 48'h0, "hard reset regs");
			$display("test modes done");
		end
	endtask
	task t_rate;
		begin
			port_enable_pin_in = 1'b1;
			measure(2048);
			for (i = 1; i < 4; i = i + 1)
			begin
				wr(3'h1, 8'(i));
				measure(2048 >> i);
			end
			$display("test rate done");
		end
	endtask
	initial
	begin
		n_fail = 0;
		checked = 0;
		sys_rst_in = 1'b1;
		word_in = 16'h0000;
		word_valid_in = 1'b0;
		port_enable_pin_in = 1'b0;
		stall = 1'b0;
		hw_reset;
		t_regs;
		t_swrst;
		t_fill;
		t_modes;
		t_rate;
		wrap_up;
	end
endmodule

// ---- tb/ccr_host_model.sv ----
// host-side sink that collects forwarded words and can stall
`timescale 1ns/1ps
module ccr_host_model (
	input  wire        ref_clk_in,
	input  wire [15:0] fwd_word_in,
	input  wire        fwd_valid_in,
	input  wire        stall_in,
	output wire        fwd_ready_out
);
	logic [15:0] got[$];
	assign fwd_ready_out = !stall_in;
	// every word taken on the forward port is kept, read replies included
	always @(posedge ref_clk_in)
		if (fwd_valid_in && fwd_ready_out)
			got.push_back(fwd_word_in);
endmodule
